// *** include/bmmc_pkg.sv ***
package bmmc_pkg;

    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int ROM_AW = 13;
    localparam int RAM_AW = 13;
    localparam int ROM_WORDS = 6144;
    localparam int RAM_WORDS = 8192;

    // Code and data space windows
    localparam logic [15:0] ROM_LO = 16'h0000;
    localparam logic [15:0] ROM_HI = 16'h17ff;
    localparam logic [15:0] ROM_MIR_LO = 16'h8000;
    localparam logic [15:0] ROM_MIR_HI = 16'h97ff;
    localparam logic [15:0] RAM_LO = 16'h0000;
    localparam logic [15:0] RAM_HI = 16'h1fff;
    localparam logic [15:0] MMR_LO = 16'hfd80;
    localparam logic [15:0] MMR_HI = 16'hffff;

    // Register addresses inside the mapped register window
    localparam logic [15:0] CFG_ADDR = 16'hff90;
    localparam logic [15:0] USB_CONTROL_REG_ADDR = 16'hff91;

    // Configuration and USB control register fields
    localparam int CFG_BOOT_MAP_BIT = 0;
    localparam int CFG_REV_LSB = 1;
    localparam int CFG_REV_MSB = 4;
    localparam int CFG_OVC_BIT = 5;
    localparam int CFG_INT1_BIT = 6;
    localparam int CFG_RSV_BIT = 7;
    localparam int REV_W = CFG_REV_MSB - CFG_REV_LSB + 1;
    localparam int USB_ATTACH_BIT = 7;

    localparam logic BIT_RESET = 1'b0;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [1:0] SETTLE_DONE = 2'h3;

    typedef enum logic [1:0] {
        BMMC_CLK_EXT48 = 2'b00,
        BMMC_CLK_RSV01 = 2'b01,
        BMMC_CLK_RSV10 = 2'b10,
        BMMC_CLK_XTAL12 = 2'b11
    } bmmc_clk_e;

    typedef struct packed {
        logic code_rd;
        logic data_rd;
        logic data_wr;
        logic [15:0] addr;
        logic [7:0] wdata;
    } bmmc_req_s;

    typedef struct packed {
        logic sel;
        logic wr;
        logic [15:0] addr;
        logic [7:0] wdata;
    } bmmc_mmr_s;

endpackage : bmmc_pkg

// *** hdl/bmmc_boot_map.sv ***
`timescale 1ns/1ps
module bmmc_boot_map
    import bmmc_pkg::*;
#(
    parameter logic [REV_W-1:0] REVISION = 4'h0, // Arbitrary value
    parameter bit ROM_ONLY = 1'b0
) (
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic func_rst_i,
    input wire bmmc_req_s mcu_req_i,
    output bmmc_mmr_s mmr_o,
    input wire logic [DATA_W-1:0] mmr_rdata_i,
    output logic [ROM_AW-1:0] rom_addr_o,
    input wire logic [DATA_W-1:0] rom_rdata_i,
    output logic [DATA_W-1:0] rdata_o,
    output logic rdata_valid_o,
    output logic boot_map_done_o,
    output logic bus_attach_o,
    output logic overcurrent_detect_enable_o,
    input wire logic clock_strap_low_i,
    input wire logic clock_strap_high_i,
    output bmmc_clk_e clk_src_o,
    output logic clk_src_rsv_o,
    input wire logic port3_bit3_pin_i,
    input wire logic [7:0] port2_in_i,
    output logic int1_o
);

    ////////////////////////////////////////////////////////////////
    function automatic logic in_range(
        input logic [15:0] a,
        input logic [15:0] lo,
        input logic [15:0] hi
    );
        in_range = (a >= lo) && (a <= hi);
    endfunction : in_range

    // Reserved strap codes are flagged, not refused; the clock tree decides
    function automatic logic strap_reserved(input bmmc_clk_e c);
        strap_reserved = (c == BMMC_CLK_RSV01) | (c == BMMC_CLK_RSV10);
    endfunction : strap_reserved

    ////////////////////////////////////////////////////////////////
    logic [DATA_W-1:0] ram_mem [RAM_WORDS];
    logic boot_map_done_r;
    logic bus_attach_r;
    logic ovc_en_r;
    logic int1_sel_r;
    logic rsv_r;
    logic [DATA_W-1:0] ram_q_r;
    logic [DATA_W-1:0] reg_q_r;
    logic hit_rom_r;
    logic hit_ram_r;
    logic hit_mmr_r;
    logic hit_reg_r;
    logic valid_r;

    wire logic [15:0] a_w = mcu_req_i.addr;
    wire logic data_acc_w = mcu_req_i.data_rd | mcu_req_i.data_wr;
    wire logic code_acc_w = mcu_req_i.code_rd & ~data_acc_w;
    wire logic any_acc_w = code_acc_w | data_acc_w;

    // Boot map while bit clear
    // variant ignores bit
    wire logic boot_w = ~boot_map_done_r | ROM_ONLY;

    ////////////////////////////////////////////////////////////////
    // boot ROM low window
    wire logic rom_low_w = code_acc_w & boot_w & in_range(a_w, ROM_LO, ROM_HI);
    wire logic rom_mir_w = code_acc_w & in_range(a_w, ROM_MIR_LO, ROM_MIR_HI);
    wire logic hit_rom_w = rom_low_w | rom_mir_w;
    wire logic [15:0] rom_off_w = rom_mir_w ? (a_w - ROM_MIR_LO) : (a_w - ROM_LO);

    wire logic ram_data_w = data_acc_w & boot_w & in_range(a_w, RAM_LO, RAM_HI);
    wire logic ram_code_w = code_acc_w & ~boot_w & in_range(a_w, RAM_LO, RAM_HI);
    wire logic hit_ram_w = ram_data_w | ram_code_w;
    wire logic ram_we_w = ram_data_w & mcu_req_i.data_wr;
    wire logic [RAM_AW-1:0] ram_idx_w = RAM_AW'(a_w - RAM_LO);

    wire logic hit_win_w = data_acc_w & in_range(a_w, MMR_LO, MMR_HI);
    wire logic hit_cfg_w = hit_win_w & (a_w == CFG_ADDR);
    wire logic hit_usb_w = hit_win_w & (a_w == USB_CONTROL_REG_ADDR);
    wire logic hit_reg_w = hit_cfg_w | hit_usb_w;
    wire logic hit_mmr_w = hit_win_w & ~hit_reg_w;
    wire logic cfg_we_w = hit_cfg_w & mcu_req_i.data_wr;
    wire logic usb_we_w = hit_usb_w & mcu_req_i.data_wr;
    wire logic [DATA_W-1:0] wd_w = mcu_req_i.wdata;

    wire logic [DATA_W-1:0] cfg_rd_w = {rsv_r, int1_sel_r, ovc_en_r, REVISION, boot_map_done_r};
    wire logic [DATA_W-1:0] usb_rd_w = DATA_W'(bus_attach_r) << USB_ATTACH_BIT;

    ////////////////////////////////////////////////////////////////
    // set only, never cleared by MCU
    wire logic boot_nxt = boot_map_done_r | (cfg_we_w & wd_w[CFG_BOOT_MAP_BIT]);
    wire logic attach_nxt = usb_we_w ? wd_w[USB_ATTACH_BIT] : bus_attach_r;

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            boot_map_done_r <= BIT_RESET;
            bus_attach_r <= BIT_RESET;
        end else if (func_rst_i) begin
            boot_map_done_r <= BIT_RESET;
            bus_attach_r <= BIT_RESET;
        end else begin
            boot_map_done_r <= boot_nxt;
            bus_attach_r <= attach_nxt;
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ovc_en_r <= BIT_RESET;
            int1_sel_r <= BIT_RESET;
            rsv_r <= BIT_RESET;
        end else if (func_rst_i) begin
            ovc_en_r <= BIT_RESET;
            int1_sel_r <= BIT_RESET;
            rsv_r <= BIT_RESET;
        end else if (cfg_we_w) begin
            ovc_en_r <= wd_w[CFG_OVC_BIT];
            int1_sel_r <= wd_w[CFG_INT1_BIT];
            rsv_r <= wd_w[CFG_RSV_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////
    // RAM is not reset; contents survive a function reset
    always_ff @(posedge core_clk_i) begin
        if (ram_we_w) begin
            ram_mem[ram_idx_w] <= wd_w;
        end
    end

    // Read port sees the old word on a same-edge write
    always_ff @(posedge core_clk_i) begin
        ram_q_r <= ram_mem[ram_idx_w];
    end

    ////////////////////////////////////////////////////////////////
    // First stage: decode captured for the answer select
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            hit_rom_r <= BIT_RESET;
            hit_ram_r <= BIT_RESET;
            hit_mmr_r <= BIT_RESET;
            hit_reg_r <= BIT_RESET;
            valid_r <= BIT_RESET;
        end else begin
            hit_rom_r <= hit_rom_w;
            hit_ram_r <= hit_ram_w;
            hit_mmr_r <= hit_mmr_w;
            hit_reg_r <= hit_reg_w;
            // Writes get no answer; every read does, mapped or not
            valid_r <= any_acc_w & ~mcu_req_i.data_wr;
        end
    end

    // Local register answer waits here for the second stage
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            reg_q_r <= BYTE_ZERO;
        end else begin
            reg_q_r <= hit_cfg_w ? cfg_rd_w : usb_rd_w;
        end
    end

    // ROM index and window port registered so the far side sees clean levels
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rom_addr_o <= '0;
            mmr_o <= '0;
        end else begin
            rom_addr_o <= ROM_AW'(rom_off_w);
            mmr_o.sel <= hit_mmr_w;
            mmr_o.wr <= hit_mmr_w & mcu_req_i.data_wr;
            mmr_o.addr <= a_w;
            mmr_o.wdata <= wd_w;
        end
    end

    ////////////////////////////////////////////////////////////////
    // unmapped reads return zero
    wire logic [DATA_W-1:0] rd_sel_w =
        hit_rom_r ? rom_rdata_i :
        hit_ram_r ? ram_q_r :
        hit_reg_r ? reg_q_r :
        hit_mmr_r ? mmr_rdata_i : BYTE_ZERO;

    // Second stage: read answer two edges after the request
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_o <= BYTE_ZERO;
            rdata_valid_o <= BIT_RESET;
        end else begin
            rdata_o <= valid_r ? rd_sel_w : BYTE_ZERO;
            rdata_valid_o <= valid_r;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Pin synchronisers; first stage feeds only the second
    localparam int NSYNC = 11;
    logic [NSYNC-1:0] pin_s1_r;
    logic [NSYNC-1:0] pin_s2_r;
    wire logic [NSYNC-1:0] pins_w = {clock_strap_high_i, clock_strap_low_i, port3_bit3_pin_i, port2_in_i};

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
        end else begin
            pin_s1_r <= pins_w;
            pin_s2_r <= pin_s1_r;
        end
    end

    wire logic [7:0] p2_w = pin_s2_r[7:0];
    wire logic p33_w = pin_s2_r[8];
    wire bmmc_clk_e strap_w = bmmc_clk_e'({pin_s2_r[9], pin_s2_r[10]});

    ////////////////////////////////////////////////////////////////
    // Straps caught once the chain has settled after release
    // Capture waits until both sync stages hold the pin level, not their reset zero
    logic [1:0] settle_r;
    wire logic settled_w = (settle_r == SETTLE_DONE);

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            settle_r <= '0;
        end else if (!settled_w) begin
            settle_r <= settle_r + 2'h1;
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            clk_src_o <= BMMC_CLK_XTAL12;
            clk_src_rsv_o <= BIT_RESET;
        end else if (settle_r == SETTLE_DONE - 2'h1) begin
            clk_src_o <= strap_w;
            clk_src_rsv_o <= strap_reserved(strap_w);
        end
    end

    ////////////////////////////////////////////////////////////////
    // INT1 source mux
    wire logic int1_w = int1_sel_r ? |p2_w : p33_w;

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            int1_o <= BIT_RESET;
        end else begin
            int1_o <= int1_w;
        end
    end

    // Status copies lag their register bits by one cycle
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            boot_map_done_o <= BIT_RESET;
            bus_attach_o <= BIT_RESET;
            overcurrent_detect_enable_o <= BIT_RESET;
        end else begin
            boot_map_done_o <= boot_map_done_r;
            bus_attach_o <= bus_attach_r;
            overcurrent_detect_enable_o <= ovc_en_r;
        end
    end

endmodule : bmmc_boot_map

// *** verification/bmmc_boot_map_monitor.sv ***
`timescale 1ns/1ps
module bmmc_boot_map_monitor
    import bmmc_pkg::*;
#(
    parameter logic [REV_W-1:0] REVISION = 4'h0
) (
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic func_rst_i,
    input wire bmmc_req_s mcu_req_i,
    input wire bmmc_mmr_s mmr_o,
    input wire logic [ROM_AW-1:0] rom_addr_o,
    input wire logic [DATA_W-1:0] rdata_o,
    input wire logic rdata_valid_o,
    input wire logic boot_map_done_o,
    input wire logic bus_attach_o,
    input wire bmmc_clk_e clk_src_o,
    input wire logic clk_src_rsv_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!arst_n_i);
    wire logic data_acc = mcu_req_i.data_rd | mcu_req_i.data_wr;
    wire logic rd_req = (mcu_req_i.code_rd | mcu_req_i.data_rd) & ~mcu_req_i.data_wr;
    wire logic cfg_hit = mcu_req_i.addr == CFG_ADDR;
    wire logic ctl_hit = mcu_req_i.addr == USB_CONTROL_REG_ADDR;
    wire logic mmr_hit = data_acc & (mcu_req_i.addr >= MMR_LO) & ~cfg_hit & ~ctl_hit;
    wire logic mir_hit = mcu_req_i.code_rd & ~data_acc & (mcu_req_i.addr >= ROM_MIR_LO) & (mcu_req_i.addr <= ROM_MIR_HI);
    ////////////////////////////////////////////////////////////////
    property p_valid_lat; rd_req |-> ##2 rdata_valid_o; endproperty
    a_valid_lat: assert property (p_valid_lat) else $error("read answer late");
    property p_valid_cause; rdata_valid_o |-> $past(rd_req, 2); endproperty
    a_valid_cause: assert property (p_valid_cause) else $error("answer without read");
    property p_mmr_sel; mmr_hit |=> mmr_o.sel && mmr_o.addr == $past(mcu_req_i.addr); endproperty
    a_mmr_sel: assert property (p_mmr_sel) else $error("register window not selected");
    property p_mmr_wr; mmr_hit && mcu_req_i.data_wr |=> mmr_o.wr && mmr_o.wdata == $past(mcu_req_i.wdata); endproperty
    a_mmr_wr: assert property (p_mmr_wr) else $error("register window write lost");
    property p_mmr_quiet; !mmr_hit |=> !mmr_o.sel; endproperty
    a_mmr_quiet: assert property (p_mmr_quiet) else $error("window selected without access");
    property p_rom_mirror; mir_hit |=> rom_addr_o == $past(mcu_req_i.addr[ROM_AW-1:0]); endproperty
    a_rom_mirror: assert property (p_rom_mirror) else $error("high ROM index wrong");
    // Write and a clash with function reset excluded
    property p_boot_set;
        !func_rst_i && mcu_req_i.data_wr && cfg_hit && mcu_req_i.wdata[CFG_BOOT_MAP_BIT] |-> ##2 boot_map_done_o;
    endproperty
    a_boot_set: assert property (p_boot_set) else $error("boot map bit not set");
    property p_boot_sticky; boot_map_done_o && !func_rst_i && !$past(func_rst_i) |=> boot_map_done_o; endproperty
    a_boot_sticky: assert property (p_boot_sticky) else $error("boot map bit dropped");
    property p_attach_set;
        !func_rst_i && mcu_req_i.data_wr && ctl_hit && mcu_req_i.wdata[USB_ATTACH_BIT] |-> ##2 bus_attach_o;
    endproperty
    a_attach_set: assert property (p_attach_set) else $error("attach not set");
    property p_func_clr; func_rst_i |-> ##2 !boot_map_done_o && !bus_attach_o; endproperty
    a_func_clr: assert property (p_func_clr) else $error("function reset ignored");
    property p_rev;
        mcu_req_i.data_rd && !mcu_req_i.data_wr && cfg_hit |-> ##2 rdata_o[CFG_REV_MSB:CFG_REV_LSB] == REVISION;
    endproperty
    a_rev: assert property (p_rev) else $error("revision field wrong");
    property p_clk_rsv; clk_src_rsv_o == (clk_src_o == BMMC_CLK_RSV01 || clk_src_o == BMMC_CLK_RSV10); endproperty
    a_clk_rsv: assert property (p_clk_rsv) else $error("reserved strap flag wrong");
endmodule : bmmc_boot_map_monitor

// *** verification/bmmc_far_model.sv ***
`timescale 1ns/1ps
module bmmc_far_model
    import bmmc_pkg::*;
(
    input wire logic [ROM_AW-1:0] rom_addr_i,
    input wire bmmc_mmr_s mmr_i,
    output logic [DATA_W-1:0] rom_rdata_o,
    output logic [DATA_W-1:0] mmr_rdata_o
);
    // Address-dependent data so a wrong index shows
    assign rom_rdata_o = rom_addr_i[7:0] ^ 8'h5a;
    // window answer; unselected bus shows the inverse so stale data never matches
    assign mmr_rdata_o = mmr_i.sel ? (mmr_i.addr[7:0] ^ 8'h3c) : ~(mmr_i.addr[7:0] ^ 8'h3c);
endmodule : bmmc_far_model

// *** verification/boot_memory_map_control_tb.sv ***
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin mismatches++; \
    $display("mismatch %s exp %h got %h", nm, exp, got); end end
module boot_memory_map_control_tb;
    import bmmc_pkg::*;
    logic core_clk_i, arst_n_i, func_rst_i, clock_strap_low_i, clock_strap_high_i, port3_bit3_pin_i;
    logic [7:0] port2_in_i, mmr_rdata_i, rom_rdata_i, rdata_o;
    logic [ROM_AW-1:0] rom_addr_o;
    bmmc_req_s mcu_req_i;
    bmmc_mmr_s mmr_o;
    bmmc_clk_e clk_src_o;
    logic rdata_valid_o, boot_map_done_o, bus_attach_o, overcurrent_detect_enable_o, clk_src_rsv_o, int1_o;
    logic [7:0] ro_rom_rdata, ro_mmr_rdata, ro_rdata;
    logic [ROM_AW-1:0] ro_rom_addr;
    bmmc_mmr_s ro_mmr;
    logic ro_valid;
    int mismatches, checks;
    initial begin
        core_clk_i = 1'b0;
        forever #12.5 core_clk_i = ~core_clk_i;
    end
    bmmc_boot_map dut_u (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .func_rst_i(func_rst_i),
        .mcu_req_i(mcu_req_i), .mmr_o(mmr_o), .mmr_rdata_i(mmr_rdata_i), .rom_addr_o(rom_addr_o),
        .rom_rdata_i(rom_rdata_i), .rdata_o(rdata_o), .rdata_valid_o(rdata_valid_o),
        .boot_map_done_o(boot_map_done_o), .bus_attach_o(bus_attach_o),
        .overcurrent_detect_enable_o(overcurrent_detect_enable_o), .clock_strap_low_i(clock_strap_low_i),
        .clock_strap_high_i(clock_strap_high_i), .clk_src_o(clk_src_o), .clk_src_rsv_o(clk_src_rsv_o),
        .port3_bit3_pin_i(port3_bit3_pin_i), .port2_in_i(port2_in_i), .int1_o(int1_o));
    bmmc_far_model far_u (.rom_addr_i(rom_addr_o), .mmr_i(mmr_o), .rom_rdata_o(rom_rdata_i),
        .mmr_rdata_o(mmr_rdata_i));
    // ROM-only variant runs on the same requests
    bmmc_boot_map #(.ROM_ONLY(1'b1)) ro_u (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
        .func_rst_i(func_rst_i), .mcu_req_i(mcu_req_i), .mmr_o(ro_mmr), .mmr_rdata_i(ro_mmr_rdata),
        .rom_addr_o(ro_rom_addr), .rom_rdata_i(ro_rom_rdata), .rdata_o(ro_rdata), .rdata_valid_o(ro_valid),
        .boot_map_done_o(), .bus_attach_o(), .overcurrent_detect_enable_o(),
        .clock_strap_low_i(clock_strap_low_i), .clock_strap_high_i(clock_strap_high_i), .clk_src_o(),
        .clk_src_rsv_o(), .port3_bit3_pin_i(port3_bit3_pin_i), .port2_in_i(port2_in_i), .int1_o());
    bmmc_far_model far_ro_u (.rom_addr_i(ro_rom_addr), .mmr_i(ro_mmr), .rom_rdata_o(ro_rom_rdata),
        .mmr_rdata_o(ro_mmr_rdata));
    ////////////////////////////////////////////////////////////////
    task automatic req(input logic c, input logic r, input logic w, input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        mcu_req_i <= '{code_rd: c, data_rd: r, data_wr: w, addr: a, wdata: d};
        @(posedge core_clk_i);
        mcu_req_i <= '0;
    endtask : req
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        req(1'b0, 1'b0, 1'b1, a, d);
    endtask : wr
    // Answer stands for one cycle only, two edges after the request edge
    task automatic rd(input logic c, input logic [15:0] a, input logic [7:0] exp, input string nm);
        req(c, ~c, 1'b0, a, 8'h00);
        @(posedge core_clk_i);
        #1;
        `CHK(nm, {1'b1, exp}, {rdata_valid_o, rdata_o})
    endtask : rd
    // Straps are taken only just after reset, so each value needs its own reset
    task automatic do_reset(input logic [1:0] straps);
        @(posedge core_clk_i);
        arst_n_i <= 1'b0;
        {clock_strap_low_i, clock_strap_high_i} <= straps;
        repeat (8) @(posedge core_clk_i);
        arst_n_i <= 1'b1;
        repeat (4) @(posedge core_clk_i);
        #1;
    endtask : do_reset
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up
    initial begin
        repeat (3000) @(posedge core_clk_i);
        mismatches++;
        wrap_up();
    end
    initial begin
        mismatches = 0;
        checks = 0;
        mcu_req_i = '0;
        func_rst_i = 1'b0;
        port3_bit3_pin_i = 1'b0;
        port2_in_i = 8'h00;
        arst_n_i = 1'b0;
        {clock_strap_low_i, clock_strap_high_i} = 2'b11;
        for (int s = 0; s < 4; s++) begin
            do_reset(s[1:0]);
            `CHK("clk_src", s[1:0], clk_src_o)
            `CHK("clk_rsv", (s == 1 || s == 2), clk_src_rsv_o)
            `CHK("rst_outs", 3'b000, {boot_map_done_o, bus_attach_o, overcurrent_detect_enable_o})
        end
        $display("test straps_reset done");
        rd(1'b1, 16'h0000, 8'h5a, "first_fetch");
        rd(1'b1, 16'h17ff, 8'ha5, "rom_top");
        rd(1'b1, 16'h8010, 8'h4a, "rom_mirror");
        rd(1'b1, 16'h1800, 8'h00, "code_gap");
        rd(1'b0, 16'hfe00, 8'h3c, "mmr_read");
        wr(16'hfe00, 8'h5c);
        rd(1'b0, CFG_ADDR, 8'h00, "cfg_reset");
        wr(16'h0010, 8'h33);
        rd(1'b0, 16'h0010, 8'h33, "ram_data");
        @(posedge core_clk_i);
        port3_bit3_pin_i <= 1'b1;
        repeat (4) @(posedge core_clk_i);
        #1;
        `CHK("int1_pin", 1'b1, int1_o)
        wr(CFG_ADDR, 8'hfe);
        rd(1'b0, CFG_ADDR, 8'he0, "cfg_fields");
        `CHK("ovc_en", 1'b1, overcurrent_detect_enable_o)
        `CHK("int1_masked", 1'b0, int1_o)
        @(posedge core_clk_i);
        port2_in_i <= 8'h04;
        repeat (6) @(posedge core_clk_i);
        #1;
        `CHK("int1_port2", 1'b1, int1_o)
        $display("test boot_map done");
        wr(16'h0000, 8'h21);
        wr(CFG_ADDR, 8'h01);
        rd(1'b1, 16'h0000, 8'h21, "ram_code");
        `CHK("rom_only_map", {1'b1, 8'h5a}, {ro_valid, ro_rdata})
        wr(16'h0010, 8'h77);
        rd(1'b1, 16'h0010, 8'h33, "ram_locked");
        rd(1'b0, 16'h0010, 8'h00, "data_gap");
        rd(1'b1, 16'h8010, 8'h4a, "rom_high");
        wr(CFG_ADDR, 8'h00);
        rd(1'b0, CFG_ADDR, 8'h01, "boot_sticky");
        wr(USB_CONTROL_REG_ADDR, 8'h80);
        rd(1'b0, USB_CONTROL_REG_ADDR, 8'h80, "attach_reg");
        `CHK("attach_pins", 2'b11, {boot_map_done_o, bus_attach_o})
        $display("test normal_map done");
        @(posedge core_clk_i);
        func_rst_i <= 1'b1;
        @(posedge core_clk_i);
        func_rst_i <= 1'b0;
        rd(1'b1, 16'h0000, 8'h5a, "refetch_rom");
        `CHK("func_rst", 2'b00, {boot_map_done_o, bus_attach_o})
        $display("test func_reset done");
        wrap_up();
    end
endmodule : boot_memory_map_control_tb
bind bmmc_boot_map bmmc_boot_map_monitor #(.REVISION(REVISION)) mon_u (.core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i), .func_rst_i(func_rst_i), .mcu_req_i(mcu_req_i), .mmr_o(mmr_o),
    .rom_addr_o(rom_addr_o), .rdata_o(rdata_o), .rdata_valid_o(rdata_valid_o),
    .boot_map_done_o(boot_map_done_o), .bus_attach_o(bus_attach_o), .clk_src_o(clk_src_o),
    .clk_src_rsv_o(clk_src_rsv_o));
